// File: lcc_config.sv
// Command decoder and clock selection for an LCD driver with PWM outputs.
// Assumes command bytes arrive already assembled, one cmd_valid pulse each,
// and that the internal oscillator is seen as a tick pulse on ref_clk.
module lcc_config (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic int_osc_tick,
  input wire logic shared_clock_pin_in,
  input wire logic display_on,
  output logic shared_clock_pin_out,
  output logic shared_clock_pin_oe,
  output logic int_osc_enable,
  output logic ext_clock_rate_select,
  output logic clock_out_enable,
  output logic clock_source_select,
  output logic [1:0] output0_mode_field,
  output logic [1:0] output1_mode_field,
  output logic [1:0] output2_mode_field,
  output logic [1:0] output3_mode_field,
  output logic [1:0] output4_mode_field,
  output logic [1:0] output5_mode_field,
  output logic [5:0] output_is_lcd,
  output logic [5:0] output_is_static,
  output logic [5:0] output_is_pwm,
  output logic pwm_active,
  output logic pwm_clk_tick,
  output logic [3:0] backplane_count,
  output logic [1:0] bias_select,
  output logic [4:0] frame_div_select,
  output logic lcd_frame_pulse,
  output logic ram_transfer_strobe
);
  import lcc_pkg::*;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Divide factor q for the fast clock; unused codes hold the nominal q.
  function automatic logic [6:0] q_of(input logic [4:0] fd);
    case (fd)
      5'h00: q_of = 7'd80;
      5'h01: q_of = 7'd68;
      5'h02: q_of = 7'd60;
      5'h03: q_of = 7'd53;
      5'h04: q_of = 7'd48;
      5'h05: q_of = 7'd44;
      5'h06: q_of = 7'd40;
      5'h07: q_of = 7'd37;
      5'h08: q_of = 7'd34;
      5'h09: q_of = 7'd32;
      5'h0A: q_of = 7'd30;
      5'h0B: q_of = 7'd28;
      5'h0C: q_of = 7'd27;
      5'h0D: q_of = 7'd25;
      5'h0E: q_of = 7'd24;
      5'h0F: q_of = 7'd23;
      5'h10: q_of = 7'd22;
      5'h11: q_of = 7'd21;
      5'h12: q_of = 7'd20;
      5'h13: q_of = 7'd19;
      5'h14: q_of = 7'd18;
      5'h15: q_of = 7'd17;
      5'h16: q_of = 7'd16;
      default: q_of = NOMINAL_Q[6:0];
    endcase
  endfunction

  function automatic logic [3:0] bp_of(input logic [1:0] m);
    case (m)
      2'h2: bp_of = 4'h6;
      2'h3: bp_of = 4'h4;
      default: bp_of = 4'h8;
    endcase
  endfunction

  function automatic logic is_pwm(input logic [1:0] m);
    is_pwm = (m == MODE_PWM);
  endfunction

  // ----------------------------------------------------------------------
  // Configuration state
  // ----------------------------------------------------------------------
  logic [1:0] mode_reg [NUM_OUTPUTS];
  logic [1:0] mode_next [NUM_OUTPUTS];
  logic rate_reg, rate_next;
  logic coe_reg, coe_next;
  logic src_reg, src_next;
  logic [1:0] mux_reg, mux_next;
  logic [1:0] bias_reg, bias_next;
  logic [4:0] fd_reg, fd_next;
  logic [3:0] bp_reg, bp_next;

  always_comb begin
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      mode_next[i] = mode_reg[i];
    end
    rate_next = rate_reg;
    coe_next = coe_reg;
    src_next = src_reg;
    mux_next = mux_reg;
    bias_next = bias_reg;
    fd_next = fd_reg;
    if (cmd_valid) begin
      if (cmd_byte[7:4] == CMD_OUT01) begin
        mode_next[1] = cmd_byte[3:2];
        mode_next[0] = cmd_byte[1:0];
      end else if (cmd_byte[7:4] == CMD_OUT23) begin
        mode_next[3] = cmd_byte[3:2];
        mode_next[2] = cmd_byte[1:0];
      end else if (cmd_byte[7:4] == CMD_OUT45) begin
        mode_next[5] = cmd_byte[3:2];
        mode_next[4] = cmd_byte[1:0];
      end else if (cmd_byte[7:2] == CMD_MUX) begin
        mux_next = cmd_byte[1:0];
      end else if (cmd_byte[7:2] == CMD_BIAS) begin
        bias_next = cmd_byte[1:0];
      end else if (cmd_byte[7:3] == CMD_OSC) begin
        rate_next = cmd_byte[OSC_RATE_BIT];
        coe_next = cmd_byte[OSC_COE_BIT];
        src_next = cmd_byte[OSC_SRC_BIT];
      end else if (cmd_byte[7:5] == CMD_FRAME) begin
        // Unused prescaler codes are dropped so the frame rate stays legal.
        if (cmd_byte[4:0] <= FD_MAX) begin
          fd_next = cmd_byte[4:0];
        end
      end
      // Any other byte belongs elsewhere and leaves this state alone.
    end
    bp_next = bp_of(mux_next);
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        mode_reg[i] <= MODE_LCD;
      end
      rate_reg <= 1'b0;
      coe_reg <= 1'b0;
      src_reg <= 1'b0;
      mux_reg <= MUX_RESET;
      bias_reg <= BIAS_RESET;
      fd_reg <= FD_RESET;
      bp_reg <= 4'h8;
    end else begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        mode_reg[i] <= mode_next[i];
      end
      rate_reg <= rate_next;
      coe_reg <= coe_next;
      src_reg <= src_next;
      mux_reg <= mux_next;
      bias_reg <= bias_next;
      fd_reg <= fd_next;
      bp_reg <= bp_next;
    end
  end

  // ----------------------------------------------------------------------
  // Clock selection
  // ----------------------------------------------------------------------
  logic pin_sync;
  logic pin_prev_reg, pin_prev_next;
  logic ext_tick;
  logic any_pwm;
  logic src_tick;
  logic [CNT_W-1:0] divisor;

  // The external clock is only sampled, never used as a clock: the host
  // must keep it running while the display is on, else frames stop.
  lcc_sync u_pin_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .async_in(shared_clock_pin_in),
    .sync_out(pin_sync)
  );

  always_comb begin
    pin_prev_next = pin_sync;
    ext_tick = pin_sync & ~pin_prev_reg;
    any_pwm = 1'b0;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      any_pwm = any_pwm | is_pwm(mode_reg[i]);
    end
    src_tick = src_reg ? ext_tick : int_osc_tick;
    if (src_reg && !rate_reg) begin
      divisor = CNT_W'(SLOW_DIV);
    end else begin
      divisor = CNT_W'(FRAME_DIV_BASE) * CNT_W'(q_of(fd_reg));
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin_prev_next;
    end
  end

  logic frame_pulse;

  lcc_frame_div #(
    .CNT_W(CNT_W)
  ) u_frame_div (
    .ref_clk(ref_clk),
    .rst(rst),
    .tick(src_tick),
    .divisor(divisor),
    .frame_pulse(frame_pulse)
  );

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  logic oe_reg, oe_next;
  logic pout_reg, pout_next;
  logic osc_en_reg, osc_en_next;
  logic pwm_act_reg, pwm_act_next;
  logic pwm_tick_reg, pwm_tick_next;
  logic lcd_pulse_reg, lcd_pulse_next;
  logic xfer_reg, xfer_next;
  logic toggle_reg, toggle_next;
  logic [5:0] lcd_reg, lcd_next;
  logic [5:0] stat_reg, stat_next;
  logic [5:0] pwm_reg, pwm_next;

  always_comb begin
    // The pin drives only while the internal oscillator is the source; an
    // external source turns it into an input.
    oe_next = coe_reg & ~src_reg;
    toggle_next = toggle_reg ^ (int_osc_tick & oe_next);
    pout_next = toggle_reg;
    // Internal oscillator runs when it is the source, or when PWM needs a
    // fast clock that the slow external one cannot give.
    osc_en_next = ~src_reg | (any_pwm & ~rate_reg);
    pwm_act_next = any_pwm;
    // PWM always runs from a fast clock.
    pwm_tick_next = (src_reg && rate_reg) ? ext_tick : int_osc_tick;
    lcd_pulse_next = frame_pulse;
    xfer_next = frame_pulse & display_on;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      lcd_next[i] = (mode_reg[i] == MODE_LCD) ||
                    (mode_reg[i] == MODE_LCD_ALT);
      stat_next[i] = (mode_reg[i] == MODE_STATIC);
      pwm_next[i] = is_pwm(mode_reg[i]);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_reg <= 1'b0;
      pout_reg <= 1'b0;
      osc_en_reg <= 1'b0;
      pwm_act_reg <= 1'b0;
      pwm_tick_reg <= 1'b0;
      lcd_pulse_reg <= 1'b0;
      xfer_reg <= 1'b0;
      toggle_reg <= 1'b0;
      lcd_reg <= 6'h3F;
      stat_reg <= 6'h00;
      pwm_reg <= 6'h00;
    end else begin
      oe_reg <= oe_next;
      pout_reg <= pout_next;
      osc_en_reg <= osc_en_next;
      pwm_act_reg <= pwm_act_next;
      pwm_tick_reg <= pwm_tick_next;
      lcd_pulse_reg <= lcd_pulse_next;
      xfer_reg <= xfer_next;
      toggle_reg <= toggle_next;
      lcd_reg <= lcd_next;
      stat_reg <= stat_next;
      pwm_reg <= pwm_next;
    end
  end

  assign shared_clock_pin_oe = oe_reg;
  assign shared_clock_pin_out = pout_reg;
  assign int_osc_enable = osc_en_reg;
  assign ext_clock_rate_select = rate_reg;
  assign clock_out_enable = coe_reg;
  assign clock_source_select = src_reg;
  assign output0_mode_field = mode_reg[0];
  assign output1_mode_field = mode_reg[1];
  assign output2_mode_field = mode_reg[2];
  assign output3_mode_field = mode_reg[3];
  assign output4_mode_field = mode_reg[4];
  assign output5_mode_field = mode_reg[5];
  assign output_is_lcd = lcd_reg;
  assign output_is_static = stat_reg;
  assign output_is_pwm = pwm_reg;
  assign pwm_active = pwm_act_reg;
  assign pwm_clk_tick = pwm_tick_reg;
  assign backplane_count = bp_reg;
  assign bias_select = bias_reg;
  assign frame_div_select = fd_reg;
  assign lcd_frame_pulse = lcd_pulse_reg;
  assign ram_transfer_strobe = xfer_reg;
endmodule

// File: lcc_pkg.sv
// Shared constants for the LCD clock and output configuration block.
// Assumes a single 100 MHz reference clock and one byte-wide command port.
package lcc_pkg;

  // ----------------------------------------------------------------------
  // Command prefixes
  // ----------------------------------------------------------------------
  localparam logic [3:0] CMD_OUT01 = 4'hC;
  localparam logic [3:0] CMD_OUT23 = 4'hD;
  localparam logic [3:0] CMD_OUT45 = 4'hE;
  localparam logic [5:0] CMD_MUX = 6'h00;
  localparam logic [5:0] CMD_BIAS = 6'h01;
  localparam logic [4:0] CMD_OSC = 5'h03;
  localparam logic [2:0] CMD_FRAME = 3'h1;

  // ----------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------
  localparam int OSC_RATE_BIT = 2;
  localparam int OSC_COE_BIT = 1;
  localparam int OSC_SRC_BIT = 0;
  localparam logic [1:0] MODE_LCD = 2'h0;
  localparam logic [1:0] MODE_LCD_ALT = 2'h1;
  localparam logic [1:0] MODE_STATIC = 2'h2;
  localparam logic [1:0] MODE_PWM = 2'h3;
  localparam logic [1:0] MUX_RESET = 2'h0;
  localparam logic [1:0] BIAS_RESET = 2'h0;
  localparam logic [4:0] FD_RESET = 5'h0E;
  localparam logic [4:0] FD_MAX = 5'h16;
  localparam int NUM_OUTPUTS = 6;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SLOW_DIV = 48;
  localparam int FRAME_DIV_BASE = 48;
  localparam int NOMINAL_Q = 24;
  localparam int CNT_W = 12;

endpackage

// File: lcc_sync.sv
// Two-stage synchroniser for one level arriving from a pin.
// Assumes the input is asynchronous to ref_clk.
module lcc_sync (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic stage1_reg;
  logic stage2_reg;
  logic stage1_next;
  logic stage2_next;

  always_comb begin
    stage1_next = async_in;
    stage2_next = stage1_reg;
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= 1'b0;
      stage2_reg <= 1'b0;
    end else begin
      stage1_reg <= stage1_next;
      stage2_reg <= stage2_next;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// File: lcc_frame_div.sv
// Frame divider: counts source clock ticks and pulses once per frame.
// Assumes tick is a one-cycle pulse on ref_clk, one per rising source clock edge.
module lcc_frame_div #(
  parameter int CNT_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic tick,
  input wire logic [CNT_W-1:0] divisor,
  output logic frame_pulse
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic pulse_reg;
  logic pulse_next;

  // The longest frame needs 48 times 80 ticks, which needs 12 bits.
  if (CNT_W < 12) begin : g_width_check
    $error("lcc_frame_div: CNT_W too small");
  end

  always_comb begin
    count_next = count_reg;
    pulse_next = 1'b0;
    if (tick) begin
      if (count_reg + 1'b1 >= divisor) begin
        count_next = '0;
        pulse_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      pulse_reg <= pulse_next;
    end
  end

  assign frame_pulse = pulse_reg;
endmodule

// File: lcc_config_checker.sv
// Port assertions for the LCD clock and output configuration block.
// Assumes it is bound to lcc_config and sees its ports by name.
module lcc_config_checker
  import lcc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_byte,
  input wire logic [1:0] output0_mode_field,
  input wire logic [1:0] output1_mode_field,
  input wire logic [1:0] output2_mode_field,
  input wire logic [1:0] output3_mode_field,
  input wire logic [1:0] output4_mode_field,
  input wire logic [1:0] output5_mode_field,
  input wire logic [5:0] output_is_lcd,
  input wire logic [5:0] output_is_static,
  input wire logic [5:0] output_is_pwm,
  input wire logic [3:0] backplane_count,
  input wire logic [1:0] bias_select,
  input wire logic ext_clock_rate_select,
  input wire logic clock_out_enable,
  input wire logic clock_source_select,
  input wire logic shared_clock_pin_oe,
  input wire logic int_osc_enable,
  input wire logic pwm_active
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // --------------------------------------------------------------------
  // Command decode and clock selection
  // --------------------------------------------------------------------
  out01_load_a:
    assert property (cmd_valid && cmd_byte[7:4] == CMD_OUT01 |=>
    {output1_mode_field, output0_mode_field} == $past(cmd_byte[3:0]))
    else $error("outputs 1 and 0 mode not loaded");
  out23_load_a:
    assert property (cmd_valid && cmd_byte[7:4] == CMD_OUT23 |=>
    {output3_mode_field, output2_mode_field} == $past(cmd_byte[3:0]))
    else $error("outputs 3 and 2 mode not loaded");
  out45_load_a:
    assert property (cmd_valid && cmd_byte[7:4] == CMD_OUT45 |=>
    {output5_mode_field, output4_mode_field} == $past(cmd_byte[3:0]))
    else $error("outputs 5 and 4 mode not loaded");
  mode_decode_a:
    assert property (output_is_pwm[0] ==
    ($past(output0_mode_field) == MODE_PWM) && output_is_static[0] ==
    ($past(output0_mode_field) == MODE_STATIC))
    else $error("output 0 mode decode wrong");
  mux_load_a:
    assert property (cmd_valid && cmd_byte[7:2] == CMD_MUX |=>
    backplane_count == ($past(cmd_byte[1]) ?
    ($past(cmd_byte[0]) ? 4'h4 : 4'h6) : 4'h8))
    else $error("backplane count wrong");
  bias_load_a:
    assert property (cmd_valid && cmd_byte[7:2] == CMD_BIAS |=>
    bias_select == $past(cmd_byte[1:0]))
    else $error("bias select not loaded");
  osc_load_a:
    assert property (cmd_valid && cmd_byte[7:3] == CMD_OSC |=>
    {ext_clock_rate_select, clock_out_enable, clock_source_select} ==
    $past(cmd_byte[2:0]))
    else $error("oscillator bits not loaded");
  no_change_a:
    assert property (cmd_valid && (cmd_byte[7:6] inside {2'h1,
    2'h2} || cmd_byte[7:4] == 4'hF) |=> $stable({output0_mode_field,
    output5_mode_field, backplane_count, bias_select, clock_source_select}))
    else $error("unmatched command changed configuration");
  pin_input_a:
    assert property (clock_source_select[*3] |->
    !shared_clock_pin_oe)
    else $error("clock pin driven with external source");
  auto_osc_a:
    assert property ((clock_source_select &&
    !ext_clock_rate_select && pwm_active)[*3] |-> int_osc_enable)
    else $error("internal oscillator not started for PWM");

  pwm_slow_c: cover property (clock_source_select && pwm_active);
  mux_four_c: cover property (backplane_count == 4'h4);
  fast_ext_c: cover property (clock_source_select && ext_clock_rate_select);
endmodule

bind lcc_config lcc_config_checker chk (.*);

// File: lcc_host.sv
// Far-side model: external clock on the shared pin and oscillator ticks.
// Assumes one ref_clk; run means an external clock is selected.
module lcc_host (
  input wire logic ref_clk,
  input wire logic run,
  output logic pin,
  output logic tick
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  logic [2:0] osc = 3'h0;
  logic pin_reg = 1'b0;
  logic tick_reg = 1'b0;

  // The pin clock has a period of 8 ref_clk cycles and stands still
  // while no external source is wanted.
  always @(posedge ref_clk) begin
    cnt <= cnt + 2'h1;
    osc <= (osc == 3'h4) ? 3'h0 : osc + 3'h1;
    tick_reg <= (osc == 3'h4);
    if (run && cnt == 2'h3) begin
      pin_reg <= ~pin_reg;
    end
  end

  assign pin = pin_reg;
  assign tick = tick_reg;
endmodule

// File: lcc_config_bench.sv
// Self-checking bench for the configuration block.
// Assumes lcc_host supplies the external pin clock and oscillator ticks.
module lcc_config_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import lcc_pkg::*;
  logic ref_clk = 0, rst = 1, cmd_valid = 0, display_on = 0, run = 0;
  logic [7:0] cmd_byte = 8'h00;
  logic int_osc_tick, host_pin, shared_clock_pin_in, shared_clock_pin_out;
  logic shared_clock_pin_oe, int_osc_enable, ext_clock_rate_select;
  logic clock_out_enable, clock_source_select, pwm_active, pwm_clk_tick;
  logic [1:0] output0_mode_field, output1_mode_field, output2_mode_field;
  logic [1:0] output3_mode_field, output4_mode_field, output5_mode_field;
  logic [5:0] output_is_lcd, output_is_static, output_is_pwm;
  logic [3:0] backplane_count;
  logic [1:0] bias_select;
  logic [4:0] frame_div_select;
  logic lcd_frame_pulse, ram_transfer_strobe;
  int num_errors = 0, checked = 0;

  always #5 ref_clk = ~ref_clk;
  assign shared_clock_pin_in = shared_clock_pin_oe ? shared_clock_pin_out
                                                   : host_pin;
  lcc_config dut (.*);
  lcc_host host (.ref_clk(ref_clk), .run(run), .pin(host_pin),
                 .tick(int_osc_tick));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  // Waits long enough for the decoded outputs, which lag by two cycles.
  task automatic send(logic [7:0] b);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_byte <= b;
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic wait_pulse(output int n, output int s);
    n = 0;
    s = 0;
    do begin
      @(posedge ref_clk);
      #1;
      n++;
      s += int'(ram_transfer_strobe === 1'b1);
    end while (lcd_frame_pulse !== 1'b1 && n < 20000);
  endtask

  // Counts PWM ticks and clock pin output changes over 40 cycles.
  task automatic count40(output int t, output int e);
    logic last;
    t = 0;
    e = 0;
    last = shared_clock_pin_out;
    repeat (40) begin
      @(posedge ref_clk);
      #1;
      t += int'(pwm_clk_tick === 1'b1);
      e += int'(shared_clock_pin_out !== last);
      last = shared_clock_pin_out;
    end
  endtask

  task automatic print_verdict;
    $display("Counts: %0d checks, %0d mismatches", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic t_reset;
    chk("is_lcd", 32'h3F, output_is_lcd);
    chk("backplanes", 32'h8, backplane_count);
    chk("bias", 32'h0, bias_select);
    chk("osc bits", 32'h0, {ext_clock_rate_select, clock_out_enable,
        clock_source_select});
    chk("frame select", 32'hE, frame_div_select);
    $display("reset test done");
  endtask

  task automatic t_modes;
    logic [1:0] a, b;
    for (int m = 0; m < 4; m++) begin
      a = 2'(m);
      b = ~a;
      send({4'hC, a, b});
      chk("out1 out0", {a, b}, {output1_mode_field, output0_mode_field});
      send({4'hD, b, a});
      chk("out3 out2", {b, a}, {output3_mode_field, output2_mode_field});
      send({4'hE, a, b});
      chk("out5 out4", {a, b}, {output5_mode_field, output4_mode_field});
      chk("pwm 5 0", {a == 2'h3, b == 2'h3},
          {output_is_pwm[5], output_is_pwm[0]});
      chk("static 0", b == 2'h2, output_is_static[0]);
      chk("lcd 5", !a[1], output_is_lcd[5]);
    end
    $display("mode test done");
  endtask

  task automatic t_mux_bias;
    logic [3:0] bp [4];
    bp = '{4'h8, 4'h8, 4'h6, 4'h4};
    for (int m = 0; m < 4; m++) begin
      send({6'h00, 2'(m)});
      chk("backplanes", bp[m], backplane_count);
      send({6'h01, 2'(m)});
      chk("bias", m, bias_select);
    end
    $display("mux and bias test done");
  endtask

  task automatic t_unmatched;
    logic [7:0] bad [4];
    logic [31:0] s;
    bad = '{8'h45, 8'h9A, 8'hF3, 8'h37};
    s = {output5_mode_field, output0_mode_field, backplane_count,
         bias_select, frame_div_select, clock_source_select};
    foreach (bad[i]) begin
      send(bad[i]);
      chk("config", s, {output5_mode_field, output0_mode_field,
          backplane_count, bias_select, frame_div_select,
          clock_source_select});
    end
    $display("unmatched test done");
  endtask

  task automatic t_osc;
    int t, e;
    send(8'h1A);
    chk("osc bits", 32'h2, {ext_clock_rate_select, clock_out_enable,
        clock_source_select});
    chk("pin oe internal", 32'h1, shared_clock_pin_oe);
    count40(t, e);
    chk("pin out edges", 32'd8, e);
    chk("pwm ticks internal", 32'd8, t);
    run <= 1'b1;
    send(8'h1B);
    chk("pin oe external", 32'h0, shared_clock_pin_oe);
    send(8'h1D);
    chk("rate fast", 32'h1, ext_clock_rate_select);
    chk("osc stopped", 32'h0, int_osc_enable);
    count40(t, e);
    chk("pwm ticks external", 32'd5, t);
    chk("pin out quiet", 32'd0, e);
    send(8'h19);
    send(8'hC3);
    chk("osc started", 32'h1, int_osc_enable);
    chk("pwm active", 32'h1, pwm_active);
    count40(t, e);
    chk("pwm ticks slow ext", 32'd8, t);
    $display("oscillator test done");
  endtask

  task automatic t_frame;
    int n, s;
    @(posedge ref_clk);
    display_on <= 1'b1;
    wait_pulse(n, s);
    wait_pulse(n, s);
    chk("slow gap", 48 * 8, n);
    chk("strobes on", 32'h1, s);
    @(posedge ref_clk);
    display_on <= 1'b0;
    wait_pulse(n, s);
    chk("strobes off", 32'h0, s);
    send(8'h36);
    chk("frame select", 32'h16, frame_div_select);
    send(8'h1D);
    wait_pulse(n, s);
    wait_pulse(n, s);
    chk("fast gap", 48 * 16 * 8, n);
    send(8'h18);
    wait_pulse(n, s);
    wait_pulse(n, s);
    chk("internal gap", 48 * 16 * 5, n);
    $display("frame test done");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    #1;
    t_reset;
    t_modes;
    t_mux_bias;
    t_unmatched;
    t_osc;
    t_frame;
    print_verdict;
  end

  // The whole run needs about 22000 cycles; this allows 50000.
  initial begin
    #500us;
    num_errors++;
    print_verdict;
  end
endmodule
